// ### src/vcr_consts.svh
//----------------------------------------------------------------------
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 16-bit register words, 7-bit register address
// Notes:   included by the register bank and its storage module
//----------------------------------------------------------------------
`ifndef VCR_CONSTS_SVH
`define VCR_CONSTS_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define VCR_OFS_PUMP_GAIN 7'h0E
`define VCR_OFS_AMPLITUDE 7'h13
`define VCR_OFS_AMP_START 7'h14
`define VCR_OFS_CAP_CODE 7'h16
`define VCR_OFS_CORE_SEL 7'h17
`define VCR_OFS_FILL_24 7'h18

// ---------------------------------------------------------------------
// storage indices
// ---------------------------------------------------------------------
`define VCR_IDX_PUMP_GAIN 3'h0
`define VCR_IDX_AMPLITUDE 3'h1
`define VCR_IDX_AMP_START 3'h2
`define VCR_IDX_CAP_CODE 3'h3
`define VCR_IDX_CORE_SEL 3'h4
`define VCR_IDX_FILL_24 3'h5
`define VCR_NUM_REGS 6

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define VCR_GAIN_MSB 1
`define VCR_GAIN_LSB 0
`define VCR_AMP_MSB 11
`define VCR_AMP_LSB 3
`define VCR_ASTART_MSB 8
`define VCR_ASTART_LSB 0
`define VCR_CAP_MSB 7
`define VCR_CAP_LSB 0
`define VCR_START_EN_BIT 14
`define VCR_SEL_MSB 13
`define VCR_SEL_LSB 11
`define VCR_FORCE_BIT 10

// ---------------------------------------------------------------------
// reset values (fields at their defaults, other bits zero)
// ---------------------------------------------------------------------
`define VCR_RST_PUMP_GAIN 16'h0001
`define VCR_RST_AMPLITUDE 16'h0960
`define VCR_RST_AMP_START 16'h012C
`define VCR_RST_CAP_CODE 16'h0000
`define VCR_RST_CORE_SEL 16'h0800
`define VCR_RST_FILL_24 16'h0000

// ---------------------------------------------------------------------
// calibration constants
// ---------------------------------------------------------------------
`define VCR_TOP_CORE 3'h7
`define VCR_AMP_MAX 9'h1FF
`define VCR_CLK_MHZ 250
`define VCR_STEP_TIME_NS 100
`define VCR_STEP_CYCLES ((`VCR_STEP_TIME_NS * `VCR_CLK_MHZ) / 1000)

`endif

// ### src/vcr_pkg.sv
//----------------------------------------------------------------------
// Purpose: types shared by the calibration control register bank
// Assumes: nothing
// Notes:   constants live in vcr_consts.svh
//----------------------------------------------------------------------
package vcr_pkg;

    typedef logic [15:0] vcr_word_t;

    typedef enum logic [1:0] {
        VCR_CAL_IDLE = 2'b00,
        VCR_CAL_RUN = 2'b01,
        VCR_CAL_DONE = 2'b10
    } vcr_cal_state_t;

endpackage : vcr_pkg

// ### src/vcr_regfile.sv
//----------------------------------------------------------------------
// Purpose: storage for the six 16-bit register words
// Assumes: one write and one read port, same clock
// Notes:   read data registered; unmapped reads return zero
//----------------------------------------------------------------------
`include "vcr_consts.svh"

module vcr_regfile
    import vcr_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [2:0] wr_idx_in,
    input wire vcr_pkg::vcr_word_t wr_data_in,
    // read port
    input wire logic rd_en_in,
    input wire logic rd_hit_in,
    input wire logic [2:0] rd_idx_in,
    output vcr_pkg::vcr_word_t rd_data_out,
    // all words, for the control logic
    output logic [16*`VCR_NUM_REGS-1:0] words_out
);

    vcr_word_t mem_q [`VCR_NUM_REGS];
    vcr_word_t mem_d [`VCR_NUM_REGS];
    vcr_word_t rd_q;
    vcr_word_t rd_d;

    function automatic vcr_word_t vcr_reset_word(input int idx);
        case (idx)
            0: vcr_reset_word = `VCR_RST_PUMP_GAIN;
            1: vcr_reset_word = `VCR_RST_AMPLITUDE;
            2: vcr_reset_word = `VCR_RST_AMP_START;
            3: vcr_reset_word = `VCR_RST_CAP_CODE;
            4: vcr_reset_word = `VCR_RST_CORE_SEL;
            default: vcr_reset_word = `VCR_RST_FILL_24;
        endcase
    endfunction : vcr_reset_word

    always_comb begin
        for (int i = 0; i < `VCR_NUM_REGS; i++) begin
            mem_d[i] = mem_q[i];
        end
        // whole-word replace on write
        if (wr_en_in) begin
            mem_d[wr_idx_in] = wr_data_in;
        end
        rd_d = rd_q;
        if (rd_en_in) begin
            rd_d = rd_hit_in ? mem_q[rd_idx_in] : 16'h0000;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < `VCR_NUM_REGS; i++) begin
                mem_q[i] <= vcr_reset_word(i);
            end
            rd_q <= 16'h0000;
        end else begin
            for (int i = 0; i < `VCR_NUM_REGS; i++) begin
                mem_q[i] <= mem_d[i];
            end
            rd_q <= rd_d;
        end
    end

    assign rd_data_out = rd_q;

    generate
        for (genvar g = 0; g < `VCR_NUM_REGS; g++) begin : g_words
            assign words_out[16*g +: 16] = mem_q[g];
        end
    endgenerate

endmodule : vcr_regfile

// ### src/vcr_bank.sv
//----------------------------------------------------------------------
// Purpose: oscillator calibration control register bank
// Assumes: register port driven by the serial port logic, same clock
// Notes:   comparator inputs are asynchronous and get synchronised
//----------------------------------------------------------------------
// What this block does
// - gain multiplier codes: 3x2.5, 2x1.5, 1x2, 0x1
// - amplitude dac nine bits 11:3, reset 300
// - amplitude override drives dac, skips calibration
// - amplitude search starts at start value, steps
// - capacitor code bits 7:0; override skips calibration
// - forced core codes 0..7 map high to low
// - start-core enable bit 14 picks start core
// - otherwise calibration starts core 7, steps down
// - core select bits 13:11, reset 1
// - force bit 10 with override selects core
`include "vcr_consts.svh"

module vcr_bank
    import vcr_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // register port
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [6:0] reg_addr_in,
    input wire vcr_pkg::vcr_word_t reg_wdata_in,
    output vcr_pkg::vcr_word_t reg_rdata_out,
    output logic reg_rvalid_out,
    // override and enable controls
    input wire logic osc_amplitude_override_in,
    input wire logic osc_capacitor_override_in,
    input wire logic amplitude_cal_enable_in,
    input wire logic frequency_cal_enable_in,
    // calibration requests and comparators
    input wire logic amp_cal_start_in,
    input wire logic freq_cal_start_in,
    input wire logic amp_below_target_in,
    input wire logic freq_target_reached_in,
    // charge pump
    output logic [1:0] pump_gain_multiplier_out,
    output logic [2:0] pump_gain_halves_out,
    // amplitude
    output logic [8:0] osc_amplitude_dac_out,
    output logic amp_cal_busy_out,
    output logic amp_cal_done_out,
    // frequency
    output logic [7:0] osc_capacitor_code_out,
    output logic [2:0] osc_core_out,
    output logic osc_core_forced_out,
    output logic freq_cal_bypass_out,
    output logic freq_cal_busy_out,
    output logic freq_cal_done_out
);

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    function automatic logic [3:0] vcr_decode(input logic [6:0] addr);
        case (addr)
            `VCR_OFS_PUMP_GAIN: vcr_decode = {1'b1, `VCR_IDX_PUMP_GAIN};
            `VCR_OFS_AMPLITUDE: vcr_decode = {1'b1, `VCR_IDX_AMPLITUDE};
            `VCR_OFS_AMP_START: vcr_decode = {1'b1, `VCR_IDX_AMP_START};
            `VCR_OFS_CAP_CODE: vcr_decode = {1'b1, `VCR_IDX_CAP_CODE};
            `VCR_OFS_CORE_SEL: vcr_decode = {1'b1, `VCR_IDX_CORE_SEL};
            `VCR_OFS_FILL_24: vcr_decode = {1'b1, `VCR_IDX_FILL_24};
            default: vcr_decode = 4'h0;
        endcase
    endfunction : vcr_decode

    // gain factor in halves
    function automatic logic [2:0] vcr_gain_halves(input logic [1:0] code);
        case (code)
            2'h3: vcr_gain_halves = 3'h5;
            2'h2: vcr_gain_halves = 3'h3;
            2'h1: vcr_gain_halves = 3'h4;
            default: vcr_gain_halves = 3'h2;
        endcase
    endfunction : vcr_gain_halves

    logic [3:0] wr_dec;
    logic [3:0] rd_dec;
    logic [16*`VCR_NUM_REGS-1:0] words;
    logic rvalid_q;
    logic rvalid_d;

    assign wr_dec = vcr_decode(reg_addr_in);
    assign rd_dec = vcr_decode(reg_addr_in);

    // -----------------------------------------------------------------
    // register storage
    // -----------------------------------------------------------------
    // read-write words
    vcr_regfile u_regfile (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .wr_en_in(reg_wr_en_in && wr_dec[3]),
        .wr_idx_in(wr_dec[2:0]),
        .wr_data_in(reg_wdata_in),
        .rd_en_in(reg_rd_en_in),
        .rd_hit_in(rd_dec[3]),
        .rd_idx_in(rd_dec[2:0]),
        .rd_data_out(reg_rdata_out),
        .words_out(words)
    );

    always_comb begin
        rvalid_d = reg_rd_en_in;
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rvalid_out = rvalid_q;

    // -----------------------------------------------------------------
    // field extraction
    // -----------------------------------------------------------------
    vcr_word_t w_gain;
    vcr_word_t w_amp;
    vcr_word_t w_astart;
    vcr_word_t w_cap;
    vcr_word_t w_core;
    logic [1:0] f_gain;
    logic [8:0] f_amp;
    logic [8:0] f_astart;
    logic [7:0] f_cap;
    logic f_start_en;
    logic [2:0] f_sel;
    logic f_force;
    logic forced;

    assign w_gain = words[16*`VCR_IDX_PUMP_GAIN +: 16];
    assign w_amp = words[16*`VCR_IDX_AMPLITUDE +: 16];
    assign w_astart = words[16*`VCR_IDX_AMP_START +: 16];
    assign w_cap = words[16*`VCR_IDX_CAP_CODE +: 16];
    assign w_core = words[16*`VCR_IDX_CORE_SEL +: 16];
    assign f_gain = w_gain[`VCR_GAIN_MSB:`VCR_GAIN_LSB];
    assign f_amp = w_amp[`VCR_AMP_MSB:`VCR_AMP_LSB];
    assign f_astart = w_astart[`VCR_ASTART_MSB:`VCR_ASTART_LSB];
    assign f_cap = w_cap[`VCR_CAP_MSB:`VCR_CAP_LSB];
    assign f_start_en = w_core[`VCR_START_EN_BIT];
    assign f_sel = w_core[`VCR_SEL_MSB:`VCR_SEL_LSB];
    assign f_force = w_core[`VCR_FORCE_BIT];
    assign forced = osc_capacitor_override_in && f_force;

    // -----------------------------------------------------------------
    // comparator synchronisers and step divider
    // -----------------------------------------------------------------
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] cmp_q;
    logic [1:0] cmp_d;
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic step_en;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmp_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : cmp_q[i];
        end
        div_d = (div_q == 8'(`VCR_STEP_CYCLES - 1)) ? 8'h00 : div_q + 8'h01;
    end

    assign step_en = (div_q == 8'(`VCR_STEP_CYCLES - 1));

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            sync3_q <= 2'h0;
            cmp_q <= 2'h0;
            div_q <= 8'h00;
        end else begin
            sync1_q <= {freq_target_reached_in, amp_below_target_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            cmp_q <= cmp_d;
            div_q <= div_d;
        end
    end

    // -----------------------------------------------------------------
    // amplitude calibration
    // -----------------------------------------------------------------
    vcr_cal_state_t acal_q;
    vcr_cal_state_t acal_d;
    logic [8:0] amp_q;
    logic [8:0] amp_d;
    logic acal_go;

    assign acal_go = amp_cal_start_in && amplitude_cal_enable_in && !osc_amplitude_override_in;

    always_comb begin
        acal_d = acal_q;
        amp_d = amp_q;
        case (acal_q)
            VCR_CAL_RUN: begin
                if (step_en) begin
                    if (cmp_q[0] && amp_q != `VCR_AMP_MAX) begin
                        amp_d = amp_q + 9'h001;
                    end else begin
                        acal_d = VCR_CAL_DONE;
                    end
                end
            end
            VCR_CAL_IDLE, VCR_CAL_DONE: begin
                acal_d = acal_q;
            end
            default: begin
                acal_d = VCR_CAL_IDLE;
            end
        endcase
        if (acal_go) begin
            acal_d = VCR_CAL_RUN;
            amp_d = f_astart;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            acal_q <= VCR_CAL_IDLE;
            amp_q <= 9'h000;
        end else begin
            acal_q <= acal_d;
            amp_q <= amp_d;
        end
    end

    // -----------------------------------------------------------------
    // frequency calibration core walk
    // -----------------------------------------------------------------
    vcr_cal_state_t fcal_q;
    vcr_cal_state_t fcal_d;
    logic [2:0] core_q;
    logic [2:0] core_d;
    logic fcal_go;

    assign fcal_go = freq_cal_start_in && frequency_cal_enable_in && !osc_capacitor_override_in;

    always_comb begin
        fcal_d = fcal_q;
        core_d = core_q;
        case (fcal_q)
            VCR_CAL_RUN: begin
                if (step_en) begin
                    if (cmp_q[1] || core_q == 3'h0) begin
                        fcal_d = VCR_CAL_DONE;
                    end else begin
                        core_d = core_q - 3'h1;
                    end
                end
            end
            VCR_CAL_IDLE, VCR_CAL_DONE: begin
                fcal_d = fcal_q;
            end
            default: begin
                fcal_d = VCR_CAL_IDLE;
            end
        endcase
        if (fcal_go) begin
            fcal_d = VCR_CAL_RUN;
            core_d = f_start_en ? f_sel : `VCR_TOP_CORE;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            fcal_q <= VCR_CAL_IDLE;
            core_q <= `VCR_TOP_CORE;
        end else begin
            fcal_q <= fcal_d;
            core_q <= core_d;
        end
    end

    // -----------------------------------------------------------------
    // registered outputs; busy and done decode the calibration state registers, freq_cal_bypass_out follows the capacitor override input unregistered
    // -----------------------------------------------------------------
    logic [1:0] gain_q;
    logic [2:0] halves_q;
    logic [8:0] dac_q;
    logic [7:0] cap_q;
    logic [2:0] core_out_q;
    logic forced_q;
    logic [1:0] gain_d;
    logic [2:0] halves_d;
    logic [8:0] dac_d;
    logic [7:0] cap_d;
    logic [2:0] core_out_d;

    always_comb begin
        gain_d = f_gain;
        halves_d = vcr_gain_halves(f_gain);
        dac_d = osc_amplitude_override_in ? f_amp : amp_q;
        cap_d = f_cap;
        core_out_d = forced ? f_sel : core_q;
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            gain_q <= 2'h1;
            halves_q <= 3'h4;
            dac_q <= 9'h000;
            cap_q <= 8'h00;
            core_out_q <= `VCR_TOP_CORE;
            forced_q <= 1'b0;
        end else begin
            gain_q <= gain_d;
            halves_q <= halves_d;
            dac_q <= dac_d;
            cap_q <= cap_d;
            core_out_q <= core_out_d;
            forced_q <= forced;
        end
    end

    assign pump_gain_multiplier_out = gain_q;
    assign pump_gain_halves_out = halves_q;
    assign osc_amplitude_dac_out = dac_q;
    assign amp_cal_busy_out = (acal_q == VCR_CAL_RUN);
    assign amp_cal_done_out = (acal_q == VCR_CAL_DONE);
    assign osc_capacitor_code_out = cap_q;
    assign osc_core_out = core_out_q;
    assign osc_core_forced_out = forced_q;
    assign freq_cal_bypass_out = osc_capacitor_override_in;
    assign freq_cal_busy_out = (fcal_q == VCR_CAL_RUN);
    assign freq_cal_done_out = (fcal_q == VCR_CAL_DONE);

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence s_write_word;
        reg_wr_en_in && wr_dec[3];
    endsequence

    sequence s_read_same;
        reg_rd_en_in && !reg_wr_en_in && (rd_dec == $past(wr_dec, 2));
    endsequence

    a_gain_scale_map: assert property (
        (f_gain == 2'h3) |=> (pump_gain_halves_out == 3'h5) && (pump_gain_multiplier_out == 2'h3))
        else $error("gain code 3 not scaled by 2.5");
    a_amp_field_pos: assert property (
        osc_amplitude_override_in
            |=> osc_amplitude_dac_out == $past(w_amp[`VCR_AMP_MSB:`VCR_AMP_LSB]))
        else $error("amplitude dac field not taken from bits 11:3");
    a_amp_override_on: assert property (
        (osc_amplitude_override_in && amp_cal_start_in) |=> !amp_cal_busy_out)
        else $error("amplitude calibration ran under override");
    a_amp_cal_load: assert property (
        acal_go |=> amp_cal_busy_out && (amp_q == $past(f_astart)))
        else $error("amplitude search did not start at start value");
    a_amp_cal_step: assert property (
        (amp_cal_busy_out && step_en && cmp_q[0] && amp_q != 9'h1FF && !acal_go)
            |=> amp_q == $past(amp_q) + 9'h001)
        else $error("amplitude search did not step up");
    a_cap_code_pass: assert property (
        ##1 osc_capacitor_code_out == $past(f_cap))
        else $error("capacitor code output lags field");
    a_core_start_sel: assert property (
        (fcal_go && f_start_en) |=> freq_cal_busy_out && core_q == $past(f_sel))
        else $error("calibration did not start at selected core");
    a_core_start_top: assert property (
        (fcal_go && !f_start_en) |=> core_q == 3'h7)
        else $error("calibration did not start at core 7");
    a_core_walk_down: assert property (
        (freq_cal_busy_out && step_en && !cmp_q[1] && core_q != 3'h0 && !fcal_go)
            |=> core_q == $past(core_q) - 3'h1)
        else $error("core walk did not step down");
    a_core_forced_sel: assert property (
        (osc_capacitor_override_in && f_force) |=> osc_core_forced_out
            && osc_core_out == $past(f_sel))
        else $error("forced core not taken from select field");
    a_write_readback: assert property (
        s_write_word ##1 !reg_wr_en_in ##1 s_read_same |=> reg_rvalid_out
            && reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("read did not return last write");

endmodule : vcr_bank

// ### bench/vcr_host.sv
// Purpose: host model programming the bank over its register port
// Assumes: one strobe per request, answer one cycle after the read edge
// Notes:   released address and data show the inverse of the last value
module vcr_host
    import vcr_pkg::*;
(
    // clock
    input wire logic mclk_in,
    // register port
    output logic reg_wr_en_out,
    output logic reg_rd_en_out,
    output logic [6:0] reg_addr_out,
    output vcr_pkg::vcr_word_t reg_wdata_out,
    input wire vcr_pkg::vcr_word_t reg_rdata_in,
    input wire logic reg_rvalid_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr_en_out = 1'b0;
        reg_rd_en_out = 1'b0;
        reg_addr_out = 7'h00;
        reg_wdata_out = 16'h0000;
    end
    task write_word(input logic [6:0] addr, input vcr_word_t data);
        @(posedge mclk_in);
        reg_wr_en_out <= 1'b1;
        reg_addr_out <= addr;
        reg_wdata_out <= data;
        @(posedge mclk_in);
        reg_wr_en_out <= 1'b0;
        reg_addr_out <= ~addr;
        reg_wdata_out <= ~data;
    endtask : write_word
    task read_word(input logic [6:0] addr, output vcr_word_t data);
        data = 16'hXXXX;
        @(posedge mclk_in);
        reg_rd_en_out <= 1'b1;
        reg_addr_out <= addr;
        @(posedge mclk_in);
        reg_rd_en_out <= 1'b0;
        reg_addr_out <= ~addr;
        for (int n = 0; n < 4; n++) begin
            @(posedge mclk_in);
            if (reg_rvalid_in === 1'b1) begin
                data = reg_rdata_in;
                break;
            end
        end
    endtask : read_word
endmodule : vcr_host

// ### bench/vcr_bank_test.sv
// Purpose: self-checking bench for the calibration control bank
// Assumes: host model drives the register port
// Notes:   comparators held steady during each calibration run, except below dropped mid-run to stop the stepped amplitude search
`include "vcr_consts.svh"
module vcr_bank_test
    import vcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [6:0] addr; vcr_word_t data;} vcr_row_t;
    logic clk, rst, wr_en, rd_en, amp_ovr, cap_ovr, amp_en, freq_en;
    logic amp_go, freq_go, below, reached, rvalid, amp_busy, amp_done;
    logic forced, bypass, freq_busy, freq_done;
    logic [6:0] addr;
    vcr_word_t wdata, rdata, got;
    logic [1:0] gain;
    logic [2:0] halves, core;
    logic [8:0] dac;
    logic [7:0] cap;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [2:0] halves_exp [4] = '{3'h2, 3'h4, 3'h3, 3'h5};
    vcr_row_t rst_rows [6] = '{'{7'h0E, 16'h0001}, '{7'h13, 16'h0960},
        '{7'h14, 16'h012C}, '{7'h16, 16'h0000}, '{7'h17, 16'h0800}, '{7'h18, 16'h0000}};
    // in-range fields; unnamed bits at their defaults
    vcr_row_t rows [6] = '{'{7'h0E, 16'h0003}, '{7'h13, 16'h0E10},
        '{7'h14, 16'h00FA}, '{7'h16, 16'h00B7}, '{7'h17, 16'h6C00}, '{7'h18, 16'h0000}};

    vcr_bank DUT(.mclk_in(clk), .reset_in(rst), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .osc_amplitude_override_in(amp_ovr),
        .osc_capacitor_override_in(cap_ovr), .amplitude_cal_enable_in(amp_en),
        .frequency_cal_enable_in(freq_en), .amp_cal_start_in(amp_go),
        .freq_cal_start_in(freq_go), .amp_below_target_in(below),
        .freq_target_reached_in(reached), .pump_gain_multiplier_out(gain),
        .pump_gain_halves_out(halves), .osc_amplitude_dac_out(dac),
        .amp_cal_busy_out(amp_busy), .amp_cal_done_out(amp_done),
        .osc_capacitor_code_out(cap), .osc_core_out(core), .osc_core_forced_out(forced),
        .freq_cal_bypass_out(bypass), .freq_cal_busy_out(freq_busy),
        .freq_cal_done_out(freq_done));
    vcr_host host(.mclk_in(clk), .reg_wr_en_out(wr_en), .reg_rd_en_out(rd_en),
        .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
        .reg_rvalid_in(rvalid));

    // ----
    // compares and closing
    // ----
    task check_word(input string nm, input vcr_word_t exp, input vcr_word_t seen);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check_word
    task check_port(input string nm, input logic [8:0] exp, input logic [8:0] seen);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check_port
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    // start pulse, then wait for done under a bound
    task run_cal(input bit freq);
        @(posedge clk);
        freq_go <= freq;
        amp_go <= !freq;
        @(posedge clk);
        freq_go <= 1'b0;
        amp_go <= 1'b0;
        for (int n = 0; n < 300; n++) begin
            @(posedge clk);
            if ((freq ? freq_done : amp_done) === 1'b1) break;
        end
        repeat (2) @(posedge clk);
    endtask : run_cal

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        {rst, amp_ovr, cap_ovr, amp_en, freq_en, amp_go, freq_go, below, reached} <= 9'h100;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (rst_rows[i]) begin
            host.read_word(rst_rows[i].addr, got);
            check_word("reset word", rst_rows[i].data, got);
        end
        $display("test reset done");
        amp_ovr <= 1'b1;
        cap_ovr <= 1'b1;
        foreach (rows[i]) begin
            host.write_word(rows[i].addr, rows[i].data);
            host.read_word(rows[i].addr, got);
            check_word("readback", rows[i].data, got);
        end
        check_port("gain halves", 9'h005, 9'(halves));
        check_port("amplitude dac", 9'h1C2, dac);
        check_port("cap code", 9'h0B7, 9'(cap));
        check_port("core", 9'h005, 9'(core));
        check_port("forced", 9'h001, 9'(forced));
        check_port("bypass", 9'h001, 9'(bypass));
        $display("test rows done");
        for (int c = 0; c < 4; c++) begin
            host.write_word(7'h0E, 16'(c));
            repeat (2) @(posedge clk);
            check_port("gain halves", 9'(halves_exp[c]), 9'(halves));
            check_port("gain field", 9'(c), 9'(gain));
        end
        host.write_word(7'h20, 16'h0FFF);
        host.read_word(7'h20, got);
        check_word("unmapped", 16'h0000, got);
        host.read_word(7'h0E, got);
        check_word("gain word", 16'h0003, got);
        $display("test gain and unmapped done");
        amp_ovr <= 1'b0;
        amp_en <= 1'b1;
        run_cal(1'b0);
        check_port("amp start", 9'h0FA, dac);
        check_port("amp done", 9'h001, 9'(amp_done));
        // below target: 300 cycles give 12 steps of 25 cycles
        below <= 1'b1;
        repeat (8) @(posedge clk);
        run_cal(1'b0);
        check_port("amp stepped", 9'h106, dac);
        check_port("amp busy", 9'h001, 9'(amp_busy));
        below <= 1'b0;
        for (int n = 0; n < 60 && amp_done !== 1'b1; n++) @(posedge clk);
        check_port("amp stop", 9'h001, 9'(amp_done));
        amp_ovr <= 1'b1;
        run_cal(1'b0);
        check_port("ovr no cal", 9'h001, 9'({amp_busy, amp_done} == 2'b01));
        check_port("ovr dac", 9'h1C2, dac);
        $display("test amplitude done");
        cap_ovr <= 1'b0;
        freq_en <= 1'b1;
        host.write_word(7'h17, 16'h2800);
        run_cal(1'b1);
        check_port("core walk end", 9'h000, 9'(core));
        check_port("freq done", 9'h001, 9'({freq_busy, freq_done} == 2'b01));
        check_port("no bypass", 9'h000, 9'(bypass));
        reached <= 1'b1;
        repeat (8) @(posedge clk);
        run_cal(1'b1);
        check_port("default start", 9'h007, 9'(core));
        host.write_word(7'h17, 16'h6800);
        run_cal(1'b1);
        check_port("chosen start", 9'h005, 9'(core));
        $display("test frequency done");
        stop_test();
    end
endmodule : vcr_bank_test
